/* File: inc/aawc_pkg.sv */
// area access wait control: shared constants, types and decode
// assumes a single 20 MHz bus clock and AHB-Lite register access

package aawc_pkg;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [31:0] AAWC_OFS_CTRL = 32'h0000_0000;
   localparam logic [31:0] AAWC_OFS_STAT = 32'h0000_0004;
   localparam logic [31:0] AAWC_WORD_MASK = 32'hffff_fffc;

   // control field layout
   localparam int AAWC_WAIT_LSB = 7;
   localparam int AAWC_WAIT_MSB = 10;
   localparam int AAWC_MASK_BIT = 6;
   localparam int AAWC_HOLD_LSB = 0;
   localparam int AAWC_HOLD_MSB = 1;
   localparam int AAWC_RSV_LSB = 2;
   localparam int AAWC_RSV_MSB = 5;

   // status field layout
   localparam int AAWC_STAT_BUSY = 0;
   localparam int AAWC_STAT_STALL = 1;

   // reset values
   localparam logic [3:0] AAWC_WAIT_RST = 4'ha;
   localparam logic AAWC_MASK_RST = 1'b0;
   localparam logic [1:0] AAWC_HOLD_RST = 2'h0;

   // ahb-lite
   localparam int AAWC_HTRANS_ACT = 1;
   localparam logic AAWC_HRESP_OKAY = 1'b0;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      AAWC_IDLE,
      AAWC_STROBE,
      AAWC_HOLD
   } aawc_state_t;

   // ------------------------------------------------------------
   // wait code to wait cycles; reserved codes fall back to longest
   // ------------------------------------------------------------
   function automatic logic [4:0] aawc_wait_cycles(input logic [3:0] code);
      case (code)
         4'h7: return 5'h08;
         4'h8: return 5'h0a;
         4'h9: return 5'h0c;
         4'ha: return 5'h0e;
         4'hb: return 5'h12;
         4'hc: return 5'h18;
         4'hd, 4'he, 4'hf: return 5'h18;
         default: return {1'b0, code};
      endcase
   endfunction

endpackage

/* File: sim/aawc_ext_mem.sv */
// area access wait control: external memory model for the bench
// assumes pins of aawc_top; wait length is set by the bench per access
`timescale 1ns/1ps

module aawc_ext_mem #(
   parameter int AW = 24,
   parameter int DW = 32
) (
   // clock
   input wire logic i_clk,
   // memory pins from the device
   input wire logic [AW-1:0] i_addr,
   input wire logic i_select_n,
   input wire logic i_rd_n,
   input wire logic [DW/8-1:0] i_lane_n,
   input wire logic [DW-1:0] i_data,
   input wire logic i_data_oe,
   input wire logic [3:0] i_wait_len,
   // answers to the device
   output logic [DW-1:0] o_data,
   output logic o_wait_n
);
   logic [DW-1:0] mem [logic [AW-1:0]];
   logic [DW-1:0] last = '0;
   int cnt = 0;

   always @(posedge i_clk) begin
      cnt <= i_select_n ? 0 : cnt + 1;
   end
   // wait held low for the first edges of each access
   assign o_wait_n = i_select_n || (cnt >= int'(i_wait_len));
   always @(posedge i_lane_n[0]) begin
      if (!i_select_n && i_data_oe) begin
         mem[i_addr] = i_data;
      end
   end
   // released bus shows the inverse of the last value
   always @(i_rd_n, i_select_n, i_addr) begin
      if (!i_rd_n && !i_select_n) begin
         o_data = mem.exists(i_addr) ? mem[i_addr] : '0;
         last = o_data;
      end else begin
         o_data = ~last;
      end
   end
endmodule

/* File: sim/tb_top.sv */
// area access wait control: self-checking bench
// assumes aawc_top, aawc_ext_mem and a 20 MHz clock
`timescale 1ns/1ps

module tb_top;
   import aawc_pkg::*;
   logic i_clk, i_rstn, i_hsel, i_hwrite, i_req, i_req_write, i_ext_wait_n;
   logic o_hreadyout, o_hresp, o_req_ready, o_done, o_area_select_n, o_rd_n, o_ext_data_oe;
   logic [31:0] i_haddr, i_hwdata, o_hrdata, i_req_wdata, o_rdata, o_ext_data, i_ext_data, rd, d;
   logic [1:0] i_htrans;
   logic [2:0] i_hsize;
   logic [23:0] i_req_addr, o_ext_addr, a;
   logic [3:0] o_byte_lane_strobe_n, wait_len;
   int n_mismatch = 0;
   int comparisons = 0;
   int wtab [13] = '{0, 1, 2, 3, 4, 5, 6, 8, 10, 12, 14, 18, 24};
   int n, e, h, m, w;
   logic [31:0] dq [$];
   realtime t_strb, t_neg, t_sel;
   wire strb_n = o_rd_n & (&o_byte_lane_strobe_n);

   aawc_top aawc_top_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_hsel(i_hsel), .i_haddr(i_haddr),
      .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
      .i_hready(o_hreadyout), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
      .i_req(i_req), .i_req_write(i_req_write), .i_req_addr(i_req_addr),
      .i_req_wdata(i_req_wdata), .o_req_ready(o_req_ready), .o_done(o_done), .o_rdata(o_rdata),
      .o_ext_addr(o_ext_addr), .o_area_select_n(o_area_select_n), .o_rd_n(o_rd_n),
      .o_byte_lane_strobe_n(o_byte_lane_strobe_n), .o_ext_data(o_ext_data),
      .o_ext_data_oe(o_ext_data_oe), .i_ext_data(i_ext_data), .i_ext_wait_n(i_ext_wait_n));
   aawc_ext_mem aawc_ext_mem_inst (.i_clk(i_clk), .i_addr(o_ext_addr),
      .i_select_n(o_area_select_n), .i_rd_n(o_rd_n), .i_lane_n(o_byte_lane_strobe_n),
      .i_data(o_ext_data), .i_data_oe(o_ext_data_oe), .i_wait_len(wait_len),
      .o_data(i_ext_data), .o_wait_n(i_ext_wait_n));

   // ------------------------------------------------------------
   // strobe and select edge times
   // ------------------------------------------------------------
   always @(negedge strb_n) t_strb = $realtime;
   always @(posedge strb_n) t_neg = $realtime;
   always @(posedge o_area_select_n) t_sel = $realtime;

   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic print_verdict;
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic edge_until(ref logic sig, input int lim, output int k);
      k = 0;
      do begin
         @(posedge i_clk);
         k++;
      end while (sig !== 1'b1 && k < lim);
      if (sig !== 1'b1) begin
         n_mismatch++;
         print_verdict();
      end
   endtask

   task automatic ahb(input logic wr, input logic [31:0] ad, input logic [31:0] wd);
      int k;
      i_hsel <= 1'b1;
      i_htrans <= 2'b10;
      i_haddr <= ad;
      i_hwrite <= wr;
      edge_until(o_hreadyout, 20, k);
      i_htrans <= 2'b00;
      i_hwdata <= wd;
      edge_until(o_hreadyout, 20, k);
      rd = o_hrdata;
   endtask

   task automatic access(input logic wr, input int nw, input int ew, input int hw);
      int k;
      i_req <= 1'b1;
      i_req_write <= wr;
      i_req_addr <= a;
      i_req_wdata <= d;
      edge_until(o_req_ready, 9, k);
      i_req <= 1'b0;
      edge_until(o_done, 80, k);
      check(32'(k), 32'(nw + ew + hw + 3));
      check(32'(int'(t_neg - t_strb)), 32'((nw + ew + 1) * 50));
      check(32'(int'(t_sel - t_neg)), 32'((2 * hw + 1) * 25));
      if (!wr) begin
         check(o_rdata, dq.pop_front());
      end
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      i_rstn = 1'b0;
      i_hsel = 1'b0;
      i_haddr = '0;
      i_htrans = 2'b00;
      i_hwrite = 1'b0;
      i_hsize = 3'b010;
      i_hwdata = '0;
      i_req = 1'b0;
      i_req_write = 1'b0;
      i_req_addr = '0;
      i_req_wdata = '0;
      wait_len = 4'h0;
      void'($urandom(32'h472c_d228));
      repeat (3) @(posedge i_clk);
      i_rstn <= 1'b1;
      @(posedge i_clk);
      ahb(1'b0, AAWC_OFS_CTRL, 32'h0000_0000);
      check(rd, 32'h0000_0500);
      a = 24'($urandom);
      d = $urandom;
      dq.push_back(d);
      access(1'b1, 14, 0, 0);
      access(1'b0, 14, 0, 0);
      ahb(1'b1, AAWC_OFS_CTRL, 32'h0000_0603);
      ahb(1'b0, AAWC_OFS_CTRL, 32'h0000_0000);
      check(rd, 32'h0000_0603);
      ahb(1'b0, 32'h0000_0008, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      // only codes 0 to 12 are ever programmed
      for (int c = 0; c < 13; c++) begin
         m = (c == 0) ? 0 : ((c == 2) ? 1 : int'($urandom_range(1)));
         h = $urandom_range(3);
         w = (c == 0) ? 3 : int'($urandom_range(9));
         n = wtab[c];
         e = (m == 1) ? 0 : ((w > n) ? w - n : 0);
         ahb(1'b1, AAWC_OFS_CTRL, 32'((c << 7) | (m << 6) | h));
         wait_len <= 4'(w);
         a = 24'($urandom);
         d = $urandom;
         dq.push_back(d);
         access(1'b1, n, e, h);
         access(1'b0, n, e, h);
      end
      print_verdict();
   end
endmodule

/* File: verilog/aawc_half_stage.sv */
// area access wait control: falling-edge retiming of strobes
// assumes the same bus clock; gives the half-cycle offset of strobes
`timescale 1ns/1ps

module aawc_half_stage #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // strobes, active low
   input wire logic [W-1:0] i_strobe_n,
   output logic [W-1:0] o_strobe_n
);

   typedef struct packed {
      logic [W-1:0] q;
   } aawc_half_t;

   aawc_half_t r;
   aawc_half_t next_r;

   generate
      if (W < 1) begin : g_chk
         $error("aawc_half_stage: W must be at least 1");
      end
   endgenerate

   always_comb begin
      next_r = r;
      next_r.q = i_strobe_n;
      if (!i_rstn) begin
         next_r.q = '1;
      end
   end

   // --------------------------------------------------------------
   // falling edge stage
   // --------------------------------------------------------------
   always_ff @(negedge i_clk) begin
      r <= next_r;
   end

   assign o_strobe_n = r.q;

endmodule

/* File: verilog/aawc_regs.sv */
// area access wait control: ahb-lite slave with control and status
// assumes one slave on the bus; answers every transfer with no wait
`timescale 1ns/1ps

module aawc_regs
   import aawc_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // ahb-lite slave
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   // configuration to the access engine
   output logic [3:0] o_wait_code,
   output logic o_wait_mask,
   output logic [1:0] o_hold_code,
   // engine state
   input wire logic i_busy,
   input wire logic i_stall
);

   typedef struct packed {
      logic ap_valid;
      logic ap_write;
      logic [31:0] ap_addr;
      logic [3:0] wait_code;
      logic wait_mask;
      logic [1:0] hold_code;
      logic [31:0] rdata;
   } aawc_regs_t;

   aawc_regs_t r;
   aawc_regs_t next_r;
   logic [31:0] word;

   always_comb begin
      next_r = r;
      next_r.ap_valid = 1'b0;
      next_r.rdata = '0;
      word = '0;
      // data phase write
      if (r.ap_valid && r.ap_write && r.ap_addr == AAWC_OFS_CTRL) begin
         next_r.wait_code = i_hwdata[AAWC_WAIT_MSB:AAWC_WAIT_LSB];
         next_r.wait_mask = i_hwdata[AAWC_MASK_BIT];
         next_r.hold_code = i_hwdata[AAWC_HOLD_MSB:AAWC_HOLD_LSB];
      end
      // address phase; read word built from post-write values
      if (i_hready && i_hsel && i_htrans[AAWC_HTRANS_ACT]) begin
         next_r.ap_valid = 1'b1;
         next_r.ap_write = i_hwrite;
         next_r.ap_addr = i_haddr & AAWC_WORD_MASK;
         if ((i_haddr & AAWC_WORD_MASK) == AAWC_OFS_CTRL) begin
            word[AAWC_WAIT_MSB:AAWC_WAIT_LSB] = next_r.wait_code;
            word[AAWC_MASK_BIT] = next_r.wait_mask;
            word[AAWC_HOLD_MSB:AAWC_HOLD_LSB] = next_r.hold_code;
         end else if ((i_haddr & AAWC_WORD_MASK) == AAWC_OFS_STAT) begin
            word[AAWC_STAT_BUSY] = i_busy;
            word[AAWC_STAT_STALL] = i_stall;
         end
         if (!i_hwrite) begin
            next_r.rdata = word;
         end
      end
      if (!i_rstn) begin
         next_r = '0;
         next_r.wait_code = AAWC_WAIT_RST;
         next_r.wait_mask = AAWC_MASK_RST;
         next_r.hold_code = AAWC_HOLD_RST;
      end
   end

   always_ff @(posedge i_clk) begin
      r <= next_r;
   end

   assign o_hrdata = r.rdata;
   assign o_hreadyout = 1'b1;
   assign o_hresp = AAWC_HRESP_OKAY;
   assign o_wait_code = r.wait_code;
   assign o_wait_mask = r.wait_mask;
   assign o_hold_code = r.hold_code;

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   rsv_read_zero_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (r.ap_valid && !r.ap_write) |-> o_hrdata[AAWC_RSV_MSB:AAWC_RSV_LSB] == 4'h0)
      else $error("reserved control bits read nonzero");

   reset_fields_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      $past(!i_rstn) |-> (r.wait_code == AAWC_WAIT_RST && !r.wait_mask && r.hold_code == 2'h0))
      else $error("control fields wrong after reset");

endmodule

/* File: verilog/aawc_top.sv */
// area access wait control: external access engine for one area
// assumes synchronous inputs on the 20 MHz bus clock
// Behaviour
// - wait code selects 0..6,8,10,12,14,18,24 cycles
// - wait code resets to 1010, fourteen cycles
// - mask 0 honours external wait, resets 0
// - mask applies also with zero wait cycles
// - bits 5..2 read zero, write zero
// - strobe to select negation 0.5..3.5 cycles
`timescale 1ns/1ps

module aawc_top
   import aawc_pkg::*;
#(
   parameter int AW = 24,
   parameter int DW = 32
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // ahb-lite register slave
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   // on-chip access request
   input wire logic i_req,
   input wire logic i_req_write,
   input wire logic [AW-1:0] i_req_addr,
   input wire logic [DW-1:0] i_req_wdata,
   output logic o_req_ready,
   output logic o_done,
   output logic [DW-1:0] o_rdata,
   // external memory pins
   output logic [AW-1:0] o_ext_addr,
   output logic o_area_select_n,
   output logic o_rd_n,
   output logic [DW/8-1:0] o_byte_lane_strobe_n,
   output logic [DW-1:0] o_ext_data,
   output logic o_ext_data_oe,
   input wire logic [DW-1:0] i_ext_data,
   input wire logic i_ext_wait_n
);

   localparam int BW = DW / 8;

   generate
      if (DW % 8 != 0 || DW < 8 || DW > 32 || AW < 1 || AW > 32) begin : g_chk
         $error("aawc_top: unsupported AW or DW");
      end
   endgenerate

   // --------------------------------------------------------------
   // state
   // --------------------------------------------------------------
   typedef struct packed {
      aawc_state_t st;
      logic [4:0] cnt;
      logic [1:0] hold;
      logic write;
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
      logic [DW-1:0] rdata;
      logic select_n;
      logic done;
      logic stall;
   } aawc_top_t;

   aawc_top_t r;
   aawc_top_t next_r;

   logic [3:0] wait_code;
   logic wait_mask;
   logic [1:0] hold_code;
   logic wait_hit;
   logic rd_pre_n;
   logic [BW-1:0] we_pre_n;

   // --------------------------------------------------------------
   // register slave
   // --------------------------------------------------------------
   aawc_regs u_regs (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_hsel(i_hsel),
      .i_haddr(i_haddr),
      .i_htrans(i_htrans),
      .i_hwrite(i_hwrite),
      .i_hsize(i_hsize),
      .i_hwdata(i_hwdata),
      .i_hready(i_hready),
      .o_hrdata(o_hrdata),
      .o_hreadyout(o_hreadyout),
      .o_hresp(o_hresp),
      .o_wait_code(wait_code),
      .o_wait_mask(wait_mask),
      .o_hold_code(hold_code),
      .i_busy(r.st != AAWC_IDLE),
      .i_stall(r.stall)
   );

   // external wait counts only when unmasked
   assign wait_hit = !wait_mask && !i_ext_wait_n;

   // --------------------------------------------------------------
   // access sequencer
   // --------------------------------------------------------------
   always_comb begin
      next_r = r;
      next_r.done = 1'b0;
      next_r.stall = 1'b0;
      case (r.st)
         AAWC_IDLE: begin
            if (i_req) begin
               next_r.st = AAWC_STROBE;
               next_r.cnt = aawc_wait_cycles(wait_code);
               next_r.write = i_req_write;
               next_r.addr = i_req_addr;
               next_r.wdata = i_req_wdata;
               next_r.select_n = 1'b0;
            end
         end
         AAWC_STROBE: begin
            if (r.cnt != 5'h00) begin
               next_r.cnt = r.cnt - 5'h01;
            end else if (wait_hit) begin
               // zero-wait accesses are stretched too
               next_r.stall = 1'b1;
            end else begin
               next_r.st = AAWC_HOLD;
               next_r.hold = hold_code;
               if (!r.write) begin
                  next_r.rdata = i_ext_data;
               end
            end
         end
         AAWC_HOLD: begin
            if (r.hold != 2'h0) begin
               next_r.hold = r.hold - 2'h1;
            end else begin
               // select negates hold code + 0.5 cycles after strobe; address keeps its value
               next_r.st = AAWC_IDLE;
               next_r.select_n = 1'b1;
               next_r.done = 1'b1;
            end
         end
         default: begin
            next_r.st = AAWC_IDLE;
            next_r.select_n = 1'b1;
         end
      endcase
      if (!i_rstn) begin
         next_r = '0;
         next_r.st = AAWC_IDLE;
         next_r.select_n = 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      r <= next_r;
   end

   // --------------------------------------------------------------
   // strobes, half a cycle after the state
   // --------------------------------------------------------------
   assign rd_pre_n = !(r.st == AAWC_STROBE && !r.write);
   assign we_pre_n = (r.st == AAWC_STROBE && r.write) ? '0 : '1;

   aawc_half_stage #(
      .W(BW + 1)
   ) u_half (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_strobe_n({rd_pre_n, we_pre_n}),
      .o_strobe_n({o_rd_n, o_byte_lane_strobe_n})
   );

   // --------------------------------------------------------------
   // outputs
   // --------------------------------------------------------------
   assign o_req_ready = r.st == AAWC_IDLE;
   assign o_done = r.done;
   assign o_rdata = r.rdata;
   assign o_ext_addr = r.addr;
   assign o_area_select_n = r.select_n;
   assign o_ext_data = r.wdata;
   assign o_ext_data_oe = r.write && !r.select_n;

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rstn);

   wait_load_a: assert property (
      (r.st == AAWC_IDLE && i_req)
         |=> (r.st == AAWC_STROBE && r.cnt == aawc_wait_cycles($past(wait_code))))
      else $error("wait count not loaded from code");

   reset_code_a: assert property (
      $past(!i_rstn) |-> wait_code == AAWC_WAIT_RST)
      else $error("wait code not 1010 after reset");

   mask_ignore_a: assert property (
      (r.st == AAWC_STROBE && r.cnt == 5'h00 && wait_mask)
         |=> r.st == AAWC_HOLD)
      else $error("masked wait still stretched access");

   zero_wait_stretch_a: assert property (
      (r.st == AAWC_IDLE && i_req && wait_code == 4'h0 && !wait_mask ##1 !i_ext_wait_n)
         |=> r.st == AAWC_STROBE)
      else $error("zero-wait access not stretched");

   wait_hold_a: assert property (
      (r.st == AAWC_STROBE && r.cnt == 5'h00 && !wait_mask && !i_ext_wait_n)
         |=> (r.st == AAWC_STROBE && r.stall))
      else $error("external wait not honoured");

   hold_load_a: assert property (
      (r.st == AAWC_STROBE && $past(r.st) == AAWC_STROBE ##1 r.st == AAWC_HOLD)
         |-> r.hold == $past(hold_code))
      else $error("hold count not taken");

   select_release_a: assert property (
      (r.st == AAWC_HOLD && r.hold == 2'h0)
         |=> (o_area_select_n && o_done ##1 !o_done))
      else $error("select not released after hold");

   strobe_len_a: assert property (
      (r.st == AAWC_IDLE && i_req && wait_code == 4'h2 && wait_mask)
         |=> (r.st == AAWC_STROBE)[*3] ##1 r.st == AAWC_HOLD)
      else $error("strobe length wrong for two waits");

   cnt_down_a: assert property (
      (r.st == AAWC_STROBE && r.cnt != 5'h00)
         |=> (r.st == AAWC_STROBE && r.cnt == $past(r.cnt) - 5'h01))
      else $error("wait counter did not step down");

   hold_down_a: assert property (
      (r.st == AAWC_HOLD && r.hold != 2'h0)
         |=> (r.st == AAWC_HOLD && r.hold == $past(r.hold) - 2'h1))
      else $error("hold counter did not step down");

   wait_release_a: assert property (
      (r.st == AAWC_STROBE && r.cnt == 5'h00 && i_ext_wait_n)
         |=> r.st == AAWC_HOLD)
      else $error("released wait still stretched access");

   stall_cause_a: assert property (
      r.stall
         |-> $past(r.st == AAWC_STROBE && r.cnt == 5'h00 && !wait_mask && !i_ext_wait_n))
      else $error("stall flag without external wait");

   read_capture_a: assert property (
      (r.st == AAWC_STROBE && r.cnt == 5'h00 && !wait_hit && !r.write)
         |=> o_rdata == $past(i_ext_data))
      else $error("read data not taken at strobe end");

   // --------------------------------------------------------------
   // checks on the pins
   // --------------------------------------------------------------
   select_idle_a: assert property (
      (r.st == AAWC_IDLE) == o_area_select_n)
      else $error("select does not follow access state");

   addr_load_a: assert property (
      (r.st == AAWC_IDLE && i_req)
         |=> (o_ext_addr == $past(i_req_addr) && !o_area_select_n))
      else $error("address not put out with select");

   read_strobe_a: assert property (
      o_rd_n == !(r.st == AAWC_STROBE && !r.write))
      else $error("read strobe not half a cycle after state");

   write_strobe_a: assert property (
      o_byte_lane_strobe_n == {BW{!(r.st == AAWC_STROBE && r.write)}})
      else $error("write strobe not half a cycle after state");

   strobe_excl_a: assert property (
      !o_rd_n |-> &o_byte_lane_strobe_n)
      else $error("read and write strobes together");

   oe_in_select_a: assert property (
      o_ext_data_oe |-> !o_area_select_n)
      else $error("data driven outside select");

   addr_stable_a: assert property (
      (!o_area_select_n && $past(!o_area_select_n)) |-> $stable(o_ext_addr))
      else $error("address moved while selected");

   wdata_stable_a: assert property (
      (o_ext_data_oe && $past(o_ext_data_oe)) |-> $stable(o_ext_data))
      else $error("write data moved while driven");

   done_pulse_a: assert property (
      o_done |-> (o_req_ready && o_area_select_n) ##1 !o_done)
      else $error("done not a single idle cycle");

   reset_pins_a: assert property (
      $past(!i_rstn)
         |-> (o_area_select_n && o_rd_n && &o_byte_lane_strobe_n && !o_done))
      else $error("pins not idle after reset");

endmodule
